/* File: design/adcr_regs.sv */
// Function
// - Switching frequency field picks 768, 384, 480 or 576 kHz; reserved codes held off.
// - Bridge bit: clear gives bridge-tied output, set gives parallel bridge output.
// - Modulation field: 0 standard, 1 low-idle, 2 hybrid.
// - DSP hold bit resets to one; clearing it releases the processor.
// - Mute bit ramps volume smoothly down; clearing ramps it back up.
// - Power field: 0 deep sleep, 1 sleep, 2 high impedance, 3 play.
// - Non-zero book page end goes to next page location 8, or wraps when disabled.
// - Ratio field encodes 32, 64, 128, 256 or 512 bit clocks per frame.
// - Rate field: auto or fixed 32 to 96 kHz; host matches actual rate.
// - PLL overrate flagged; ignore bit keeps it out of the clock error.
// - Bit clock outside 256 kHz to 50 MHz flagged; ignore bit keeps it out of the clock error.
// - Ignored frame-rate error still shows in status, not in clock error.
// - Bit clocks per frame outside 32 to 512 flagged; ignore bit keeps it out of the clock error.
// - Missing bit clock raises clock error unless ignored.
module adcr_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h2C, // Arbitrary bus address
	parameter int CLK_FREQ_KHZ = 250000,
	parameter int RAMP_STEP = adcr_pkg::RAMP_STEP_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda,
	output logic sdaDrv,
	output logic sdaOe,
	input wire logic bitClock,
	input wire logic frameClock,
	input wire logic pllOverrate,
	output logic [9:0] switchFreqKhz,
	output logic bridgeParallel,
	output adcr_pkg::adcr_mod_t modScheme,
	output logic dspHoldInReset,
	output logic [7:0] volumeGain,
	output adcr_pkg::adcr_pwr_t powerState,
	output logic [9:0] bitclkRatioFs,
	output logic [3:0] sampleRateSel,
	output logic [4:0] clockDetectStatus,
	output logic clockError
);
	logic sclM_q, sclS_q, sclP_q, sdaM_q, sdaS_q, sdaP_q;
	logic sclRise, sclFall, startCond, stopCond;
	adcr_pkg::adcr_port_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, page_q, page_d, book_q, book_d, rdData, ptrByte;
	logic [6:0] ptr_q, ptr_d;
	logic rw_q, rw_d, ptrPend_q, ptrPend_d, oe_q, oe_d, wrEn, regWr;
	logic [14:0] loc;
	logic [7:0] cfgOne_q, cfgOne_d, cfgTwo_q, cfgTwo_d, pageInc_q, pageInc_d;
	logic [7:0] sigCh_q, sigCh_d, clkDet_q, clkDet_d;
	logic [9:0] swf_q, swf_d, ratio_q, ratio_d;
	adcr_pkg::adcr_mod_t mod_q, mod_d;
	logic [3:0] rate_q, rate_d;

	adcr_det_if detBus ();

	// Next page and location after one auto-increment step
	function automatic logic [14:0] nextLoc(input logic [7:0] book, input logic [7:0] page,
		input logic [6:0] ptr, input logic noWrap);
		if (ptr != adcr_pkg::PAGE_LAST_PTR) begin
			return {page, 7'(ptr + 7'h01)};
		end else if (book == 8'h00 || noWrap) begin
			return {page, 7'h00};
		end else begin
			return {8'(page + 8'h01), adcr_pkg::PAGE_WRAP_PTR};
		end
	endfunction

	function automatic logic [9:0] swfDecode(input logic [2:0] code, input logic [9:0] hold);
		case (code)
			adcr_pkg::SWF_768K: return 10'h300;
			adcr_pkg::SWF_384K: return 10'h180;
			adcr_pkg::SWF_480K: return 10'h1E0;
			adcr_pkg::SWF_576K: return 10'h240;
			default: return hold;
		endcase
	endfunction

	function automatic logic [9:0] ratioDecode(input logic [3:0] code, input logic [9:0] hold);
		case (code)
			adcr_pkg::RATIO_32FS: return 10'h020;
			adcr_pkg::RATIO_64FS: return 10'h040;
			adcr_pkg::RATIO_128FS: return 10'h080;
			adcr_pkg::RATIO_256FS: return 10'h100;
			adcr_pkg::RATIO_512FS: return 10'h200;
			default: return hold;
		endcase
	endfunction

	function automatic logic rateLegal(input logic [3:0] code);
		return code == adcr_pkg::RATE_AUTO || code == adcr_pkg::RATE_32K
			|| code == adcr_pkg::RATE_44K1 || code == adcr_pkg::RATE_48K
			|| code == adcr_pkg::RATE_88K2 || code == adcr_pkg::RATE_96K;
	endfunction

	// Control port pin synchronisers and bus conditions
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclM_q <= 1'b1;
			sclS_q <= 1'b1;
			sclP_q <= 1'b1;
			sdaM_q <= 1'b1;
			sdaS_q <= 1'b1;
			sdaP_q <= 1'b1;
		end else begin
			sclM_q <= scl;
			sclS_q <= sclM_q;
			sclP_q <= sclS_q;
			sdaM_q <= sda;
			sdaS_q <= sdaM_q;
			sdaP_q <= sdaS_q;
		end
	end

	assign sclRise = sclS_q & ~sclP_q;
	assign sclFall = ~sclS_q & sclP_q;
	assign startCond = sclS_q & sclP_q & sdaP_q & ~sdaS_q;
	assign stopCond = sclS_q & sclP_q & ~sdaP_q & sdaS_q;
	assign ptrByte = {1'b0, ptr_q};
	assign loc = nextLoc(book_q, page_q, ptr_q, pageInc_q[adcr_pkg::POS_WRAP_DIS]);
	assign regWr = wrEn && book_q == 8'h00 && page_q == 8'h00;

	// Read mux
	always_comb begin
		rdData = 8'h00;
		if (ptrByte == adcr_pkg::OFF_PAGE_SEL) begin
			rdData = page_q;
		end else if (page_q == 8'h00 && ptrByte == adcr_pkg::OFF_BOOK_SEL) begin
			rdData = book_q;
		end else if (book_q != 8'h00 || page_q != 8'h00) begin
			rdData = 8'h00;
		end else if (ptrByte == adcr_pkg::OFF_CFG_ONE) begin
			rdData = cfgOne_q;
		end else if (ptrByte == adcr_pkg::OFF_CFG_TWO) begin
			rdData = cfgTwo_q;
		end else if (ptrByte == adcr_pkg::OFF_PAGE_INC) begin
			rdData = pageInc_q;
		end else if (ptrByte == adcr_pkg::OFF_SIG_CH) begin
			rdData = sigCh_q;
		end else if (ptrByte == adcr_pkg::OFF_CLK_DET) begin
			rdData = clkDet_q;
		end else if (ptrByte == adcr_pkg::OFF_SER_OUT) begin
			rdData = adcr_pkg::RST_SER_OUT;
		end else if (ptrByte == adcr_pkg::OFF_CLK_STATUS) begin
			rdData = {2'b00, detBus.clockError, detBus.errors};
		end
	end

	// Control port transaction engine
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rw_d = rw_q;
		ptrPend_d = ptrPend_q;
		ptr_d = ptr_q;
		page_d = page_q;
		book_d = book_q;
		oe_d = oe_q;
		wrEn = 1'b0;
		if (startCond) begin
			st_d = adcr_pkg::ST_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (stopCond) begin
			st_d = adcr_pkg::ST_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				adcr_pkg::ST_ADDR, adcr_pkg::ST_WR: begin
					if (sclRise) begin
						sh_d = {sh_q[6:0], sdaS_q};
						cnt_d = 4'(cnt_q + 4'h1);
					end else if (sclFall && cnt_q == 4'h8) begin
						cnt_d = 4'h0;
						if (st_q == adcr_pkg::ST_WR) begin
							st_d = adcr_pkg::ST_WR_ACK;
							oe_d = 1'b1;
							if (ptrPend_q) begin
								ptr_d = sh_q[6:0];
								ptrPend_d = 1'b0;
							end else begin
								wrEn = 1'b1;
								{page_d, ptr_d} = loc;
								if (ptrByte == adcr_pkg::OFF_PAGE_SEL) begin
									page_d = sh_q;
								end else if (page_q == 8'h00 && ptrByte == adcr_pkg::OFF_BOOK_SEL) begin
									book_d = sh_q;
								end
							end
						end else if (sh_q[7:1] == DEV_ADDR) begin
							st_d = adcr_pkg::ST_ADDR_ACK;
							oe_d = 1'b1;
							rw_d = sh_q[0];
							ptrPend_d = ~sh_q[0];
						end else begin
							st_d = adcr_pkg::ST_IDLE;
						end
					end
				end
				adcr_pkg::ST_ADDR_ACK, adcr_pkg::ST_WR_ACK: begin
					if (sclFall) begin
						oe_d = 1'b0;
						st_d = adcr_pkg::ST_WR;
						if (rw_q) begin
							sh_d = rdData;
							oe_d = ~rdData[7];
							st_d = adcr_pkg::ST_RD;
						end
					end
				end
				adcr_pkg::ST_RD: begin
					if (sclRise) begin
						cnt_d = 4'(cnt_q + 4'h1);
					end else if (sclFall && cnt_q == 4'h8) begin
						oe_d = 1'b0;
						cnt_d = 4'h0;
						{page_d, ptr_d} = loc;
						st_d = adcr_pkg::ST_RD_ACK;
					end else if (sclFall) begin
						sh_d = {sh_q[6:0], 1'b0};
						oe_d = ~sh_q[6];
					end
				end
				adcr_pkg::ST_RD_ACK: begin
					if (sclRise && sdaS_q) begin
						st_d = adcr_pkg::ST_IDLE;
					end else if (sclFall) begin
						sh_d = rdData;
						oe_d = ~rdData[7];
						st_d = adcr_pkg::ST_RD;
					end
				end
				default: begin
					st_d = adcr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= adcr_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'b0;
			ptrPend_q <= 1'b0;
			ptr_q <= 7'h00;
			page_q <= 8'h00;
			book_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rw_q <= rw_d;
			ptrPend_q <= ptrPend_d;
			ptr_q <= ptr_d;
			page_q <= page_d;
			book_q <= book_d;
			oe_q <= oe_d;
		end
	end

	// Register bank writes; reserved codes keep the last legal setting
	always_comb begin
		cfgOne_d = cfgOne_q;
		cfgTwo_d = cfgTwo_q;
		pageInc_d = pageInc_q;
		sigCh_d = sigCh_q;
		clkDet_d = clkDet_q;
		swf_d = swf_q;
		mod_d = mod_q;
		ratio_d = ratio_q;
		rate_d = rate_q;
		if (regWr && ptrByte == adcr_pkg::OFF_CFG_ONE) begin
			cfgOne_d = sh_q;
			swf_d = swfDecode(sh_q[adcr_pkg::POS_SWF +: 3], swf_q);
			if (sh_q[1:0] != 2'b11) begin
				mod_d = adcr_pkg::adcr_mod_t'(sh_q[1:0]);
			end
		end else if (regWr && ptrByte == adcr_pkg::OFF_CFG_TWO) begin
			cfgTwo_d = sh_q;
		end else if (regWr && ptrByte == adcr_pkg::OFF_PAGE_INC) begin
			pageInc_d = sh_q;
		end else if (regWr && ptrByte == adcr_pkg::OFF_SIG_CH) begin
			sigCh_d = sh_q;
			ratio_d = ratioDecode(sh_q[adcr_pkg::POS_RATIO +: 4], ratio_q);
			if (rateLegal(sh_q[3:0])) begin
				rate_d = sh_q[3:0];
			end
		end else if (regWr && ptrByte == adcr_pkg::OFF_CLK_DET) begin
			clkDet_d = sh_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfgOne_q <= adcr_pkg::RST_CFG_ONE;
			cfgTwo_q <= adcr_pkg::RST_CFG_TWO;
			pageInc_q <= adcr_pkg::RST_PAGE_INC;
			sigCh_q <= adcr_pkg::RST_SIG_CH;
			clkDet_q <= adcr_pkg::RST_CLK_DET;
			swf_q <= 10'h300;
			mod_q <= adcr_pkg::MOD_STANDARD;
			ratio_q <= 10'h000;
			rate_q <= adcr_pkg::RATE_AUTO;
		end else begin
			cfgOne_q <= cfgOne_d;
			cfgTwo_q <= cfgTwo_d;
			pageInc_q <= pageInc_d;
			sigCh_q <= sigCh_d;
			clkDet_q <= clkDet_d;
			swf_q <= swf_d;
			mod_q <= mod_d;
			ratio_q <= ratio_d;
			rate_q <= rate_d;
		end
	end

	assign detBus.ignore = clkDet_q[adcr_pkg::POS_IGNORE +: 5];
	assign detBus.rateSel = rate_q;

	adcr_clk_detect #(.CLK_FREQ_KHZ(CLK_FREQ_KHZ)) uDetect (
		.clk(clk),
		.rst_b(rst_b),
		.bitClock(bitClock),
		.frameClock(frameClock),
		.pllOverrate(pllOverrate),
		.det(detBus.det)
	);

	adcr_mute_ramp #(.STEP_CYC(RAMP_STEP)) uRamp (
		.clk(clk),
		.rst_b(rst_b),
		.mute(cfgTwo_q[adcr_pkg::POS_MUTE]),
		.gain(volumeGain)
	);

	assign sdaDrv = 1'b0;
	assign sdaOe = oe_q;
	assign switchFreqKhz = swf_q;
	assign bridgeParallel = cfgOne_q[adcr_pkg::POS_BRIDGE];
	assign modScheme = mod_q;
	assign dspHoldInReset = cfgTwo_q[adcr_pkg::POS_DSP_HOLD];
	assign powerState = adcr_pkg::adcr_pwr_t'(cfgTwo_q[1:0]);
	assign bitclkRatioFs = ratio_q;
	assign sampleRateSel = rate_q;
	assign clockDetectStatus = detBus.errors;
	assign clockError = detBus.clockError;

	AST_SWF_384: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && ptrByte == adcr_pkg::OFF_CFG_ONE && sh_q[6:4] == 3'h1) |=> switchFreqKhz == 10'h180)
		else $error("Switching frequency code one not decoded");

	AST_SWF_RESERVED: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && ptrByte == adcr_pkg::OFF_CFG_ONE && sh_q[6:4] == 3'h2) |=> $stable(switchFreqKhz))
		else $error("Reserved switching code changed frequency");

	AST_BRIDGE: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && ptrByte == adcr_pkg::OFF_CFG_ONE) |=> bridgeParallel == $past(sh_q[2]))
		else $error("Bridge mode does not follow write");

	AST_HYBRID: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && ptrByte == adcr_pkg::OFF_CFG_ONE && sh_q[1:0] == 2'b10) |=> modScheme == adcr_pkg::MOD_HYBRID)
		else $error("Hybrid modulation not selected");

	AST_DSP_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && ptrByte == adcr_pkg::OFF_CFG_TWO && !sh_q[4]) |=> !dspHoldInReset)
		else $error("DSP hold not released");

	AST_PLAY: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && ptrByte == adcr_pkg::OFF_CFG_TWO && sh_q[1:0] == 2'b11) |=> powerState == adcr_pkg::PWR_PLAY)
		else $error("Play state not entered");

	AST_PAGE_ADVANCE: assert property (@(posedge clk) disable iff (!rst_b)
		(wrEn && book_q != 8'h00 && ptr_q == 7'h7F && !pageInc_q[3])
		|=> (ptr_q == 7'h08 && page_q == 8'($past(page_q) + 8'h01)))
		else $error("Page end did not advance to next page");

	AST_RATIO_512: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && ptrByte == adcr_pkg::OFF_SIG_CH && sh_q[7:4] == 4'hB) |=> bitclkRatioFs == 10'h200)
		else $error("Ratio code not decoded");

	AST_RATE_RESERVED: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && ptrByte == adcr_pkg::OFF_SIG_CH && sh_q[3:0] == 4'h7) |=> $stable(sampleRateSel))
		else $error("Reserved rate code accepted");
endmodule

/* File: inc/adcr_pkg.sv */
package adcr_pkg;

	// Register offsets within book 0, page 0
	localparam logic [7:0] OFF_PAGE_SEL = 8'h00;
	localparam logic [7:0] OFF_CFG_ONE = 8'h02;
	localparam logic [7:0] OFF_CFG_TWO = 8'h03;
	localparam logic [7:0] OFF_PAGE_INC = 8'h0F;
	localparam logic [7:0] OFF_SIG_CH = 8'h28;
	localparam logic [7:0] OFF_CLK_DET = 8'h29;
	localparam logic [7:0] OFF_SER_OUT = 8'h30;
	localparam logic [7:0] OFF_CLK_STATUS = 8'h39;
	localparam logic [7:0] OFF_BOOK_SEL = 8'h7F;

	// Values after reset
	localparam logic [7:0] RST_CFG_ONE = 8'h00;
	localparam logic [7:0] RST_CFG_TWO = 8'h10;
	localparam logic [7:0] RST_PAGE_INC = 8'h00;
	localparam logic [7:0] RST_SIG_CH = 8'h00;
	localparam logic [7:0] RST_CLK_DET = 8'h00;
	localparam logic [7:0] RST_SER_OUT = 8'h00;

	// Field positions
	localparam int POS_SWF = 4;
	localparam int POS_BRIDGE = 2;
	localparam int POS_DSP_HOLD = 4;
	localparam int POS_MUTE = 3;
	localparam int POS_WRAP_DIS = 3;
	localparam int POS_RATIO = 4;
	localparam int POS_IGNORE = 2;

	// Error bit order, shared by ignore field and status
	localparam int ERR_MISS = 0;
	localparam int ERR_RATIO = 1;
	localparam int ERR_FS = 2;
	localparam int ERR_RANGE = 3;
	localparam int ERR_PLL = 4;

	// Field codes
	localparam logic [2:0] SWF_768K = 3'h0;
	localparam logic [2:0] SWF_384K = 3'h1;
	localparam logic [2:0] SWF_480K = 3'h3;
	localparam logic [2:0] SWF_576K = 3'h4;
	localparam logic [3:0] RATIO_32FS = 4'h3;
	localparam logic [3:0] RATIO_64FS = 4'h5;
	localparam logic [3:0] RATIO_128FS = 4'h7;
	localparam logic [3:0] RATIO_256FS = 4'h9;
	localparam logic [3:0] RATIO_512FS = 4'hB;
	localparam logic [3:0] RATE_AUTO = 4'h0;
	localparam logic [3:0] RATE_32K = 4'h6;
	localparam logic [3:0] RATE_44K1 = 4'h8;
	localparam logic [3:0] RATE_48K = 4'h9;
	localparam logic [3:0] RATE_88K2 = 4'hA;
	localparam logic [3:0] RATE_96K = 4'hB;

	// Auto-increment page walk
	localparam logic [6:0] PAGE_LAST_PTR = 7'h7F;
	localparam logic [6:0] PAGE_WRAP_PTR = 7'h08;

	// Timing at the internal clock
	localparam int CLK_PERIOD_PS = 4000;
	localparam int BITCLK_MAX_PERIOD_PS = 3906250;
	localparam int BITCLK_MIN_PERIOD_PS = 20000;
	localparam int BITCLK_MAX_PERIOD_CYC = BITCLK_MAX_PERIOD_PS / CLK_PERIOD_PS;
	localparam int BITCLK_MIN_PERIOD_CYC = (BITCLK_MIN_PERIOD_PS + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int BITCLK_MISS_CYC = 2 * BITCLK_MAX_PERIOD_CYC;
	localparam int RATIO_MIN = 32;
	localparam int RATIO_MAX = 512;
	localparam int RAMP_STEP_CYC = 256;

	typedef enum logic [1:0] {
		MOD_STANDARD = 2'b00,
		MOD_LOW_IDLE = 2'b01,
		MOD_HYBRID = 2'b10
	} adcr_mod_t;

	typedef enum logic [1:0] {
		PWR_DEEP_SLEEP = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_HIGH_Z = 2'b10,
		PWR_PLAY = 2'b11
	} adcr_pwr_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR = 3'b011,
		ST_WR_ACK = 3'b100,
		ST_RD = 3'b101,
		ST_RD_ACK = 3'b110
	} adcr_port_t;

endpackage

/* File: inc/adcr_det_if.sv */
interface adcr_det_if;
	logic [4:0] ignore;
	logic [3:0] rateSel;
	logic [4:0] errors;
	logic clockError;

	modport det (input ignore, input rateSel, output errors, output clockError);
	modport ctl (output ignore, output rateSel, input errors, input clockError);
endinterface

/* File: design/adcr_mute_ramp.sv */
module adcr_mute_ramp #(
	parameter int STEP_CYC = adcr_pkg::RAMP_STEP_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic mute,
	output logic [7:0] gain
);
	logic [15:0] div_q, div_d;
	logic [7:0] gain_q, gain_d;
	logic tick;

	assign tick = (div_q == 16'(STEP_CYC - 1));
	assign gain = gain_q;

	// Gain walks one step per tick toward silence or full scale
	always_comb begin
		div_d = tick ? 16'h0000 : 16'(div_q + 16'h0001);
		gain_d = gain_q;
		if (tick && mute && gain_q != 8'h00) begin
			gain_d = 8'(gain_q - 8'h01);
		end else if (tick && !mute && gain_q != 8'hFF) begin
			gain_d = 8'(gain_q + 8'h01);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 16'h0000;
			gain_q <= 8'h00;
		end else begin
			div_q <= div_d;
			gain_q <= gain_d;
		end
	end

	AST_MUTE_NO_RISE: assert property (@(posedge clk) disable iff (!rst_b)
		mute |=> gain_q <= $past(gain_q))
		else $error("Gain rose while muted");

	AST_MUTE_STEP_DOWN: assert property (@(posedge clk) disable iff (!rst_b)
		(mute && tick && gain_q != 8'h00) |=> gain_q == 8'($past(gain_q) - 8'h01))
		else $error("Muted gain did not step down by one");
endmodule

/* File: design/adcr_clk_detect.sv */
module adcr_clk_detect #(
	parameter int CLK_FREQ_KHZ = 250000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bitClock,
	input wire logic frameClock,
	input wire logic pllOverrate,
	adcr_det_if.det det
);
	logic [2:0] bSy_q, fSy_q;
	logic [1:0] pSy_q;
	logic [11:0] bPer_q, bPer_d;
	logic [15:0] fPer_q, fPer_d;
	logic [10:0] cnt_q, cnt_d;
	logic [4:0] err_q, err_d;
	logic ce_q, ce_d;
	logic bRise, fRise;

	function automatic logic [15:0] frameCyc(input logic [3:0] code);
		case (code)
			adcr_pkg::RATE_32K: return 16'(CLK_FREQ_KHZ * 1000 / 32000);
			adcr_pkg::RATE_44K1: return 16'(CLK_FREQ_KHZ * 1000 / 44100);
			adcr_pkg::RATE_48K: return 16'(CLK_FREQ_KHZ * 1000 / 48000);
			adcr_pkg::RATE_88K2: return 16'(CLK_FREQ_KHZ * 1000 / 88200);
			adcr_pkg::RATE_96K: return 16'(CLK_FREQ_KHZ * 1000 / 96000);
			default: return 16'h0000;
		endcase
	endfunction

	// Frame period window: one eighth either side, or the whole range in auto mode
	function automatic logic frameOk(input logic [15:0] per, input logic [3:0] code);
		logic [15:0] lo;
		logic [15:0] hi;
		lo = frameCyc(adcr_pkg::RATE_96K);
		hi = frameCyc(adcr_pkg::RATE_32K);
		if (frameCyc(code) != 16'h0000) begin
			lo = frameCyc(code);
			hi = frameCyc(code);
		end
		return (per >= 16'(lo - (lo >> 3))) && (per <= 16'(hi + (hi >> 3)));
	endfunction

	assign bRise = bSy_q[1] & ~bSy_q[2];
	assign fRise = fSy_q[1] & ~fSy_q[2];
	assign det.errors = err_q;
	assign det.clockError = ce_q;

	always_comb begin
		bPer_d = (bPer_q == 12'hFFF) ? bPer_q : 12'(bPer_q + 12'h001);
		fPer_d = (fPer_q == 16'hFFFF) ? fPer_q : 16'(fPer_q + 16'h0001);
		cnt_d = cnt_q;
		err_d = err_q;
		if (bRise) begin
			err_d[adcr_pkg::ERR_RANGE] = (bPer_q < 12'(adcr_pkg::BITCLK_MIN_PERIOD_CYC))
				|| (bPer_q > 12'(adcr_pkg::BITCLK_MAX_PERIOD_CYC));
			err_d[adcr_pkg::ERR_MISS] = 1'b0;
			bPer_d = 12'h001;
			cnt_d = (cnt_q == 11'h7FF) ? cnt_q : 11'(cnt_q + 11'h001);
		end else if (bPer_q >= 12'(adcr_pkg::BITCLK_MISS_CYC)) begin
			err_d[adcr_pkg::ERR_MISS] = 1'b1;
		end
		if (fRise) begin
			err_d[adcr_pkg::ERR_RATIO] = (cnt_q < 11'(adcr_pkg::RATIO_MIN))
				|| (cnt_q > 11'(adcr_pkg::RATIO_MAX));
			err_d[adcr_pkg::ERR_FS] = !frameOk(fPer_q, det.rateSel);
			fPer_d = 16'h0001;
			cnt_d = bRise ? 11'h001 : 11'h000;
		end
		err_d[adcr_pkg::ERR_PLL] = pSy_q[1];
		ce_d = |(err_q & ~det.ignore);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bSy_q <= 3'h0;
			fSy_q <= 3'h0;
			pSy_q <= 2'h0;
			bPer_q <= 12'h000;
			fPer_q <= 16'h0000;
			cnt_q <= 11'h000;
			err_q <= 5'h00;
			ce_q <= 1'b0;
		end else begin
			bSy_q <= {bSy_q[1:0], bitClock};
			fSy_q <= {fSy_q[1:0], frameClock};
			pSy_q <= {pSy_q[0], pllOverrate};
			bPer_q <= bPer_d;
			fPer_q <= fPer_d;
			cnt_q <= cnt_d;
			err_q <= err_d;
			ce_q <= ce_d;
		end
	end

	AST_PLL_IGNORED: assert property (@(posedge clk) disable iff (!rst_b)
		(err_q == 5'h10 && det.ignore[adcr_pkg::ERR_PLL]) |=> !ce_q)
		else $error("Ignored PLL overrate raised clock error");

	AST_RANGE_SLOW: assert property (@(posedge clk) disable iff (!rst_b)
		(bRise && bPer_q > 12'(adcr_pkg::BITCLK_MAX_PERIOD_CYC)) |=> err_q[adcr_pkg::ERR_RANGE])
		else $error("Slow bit clock not flagged");

	AST_FS_REPORTED: assert property (@(posedge clk) disable iff (!rst_b)
		(err_q == 5'h04 && det.ignore == 5'h04) |=> (!ce_q && det.errors[adcr_pkg::ERR_FS]))
		else $error("Ignored frame error handled wrongly");

	AST_RATIO_LOW: assert property (@(posedge clk) disable iff (!rst_b)
		(fRise && cnt_q < 11'(adcr_pkg::RATIO_MIN)) |=> err_q[adcr_pkg::ERR_RATIO])
		else $error("Low bit clock ratio not flagged");

	AST_MISS_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
		(!bRise && bPer_q >= 12'(adcr_pkg::BITCLK_MISS_CYC)) |=> ##1 (ce_q || det.ignore[0]))
		else $error("Missing bit clock gave no clock error");
endmodule

/* File: verif/adcr_host_model.sv */
module adcr_host_model #(
	parameter logic [6:0] ADDR = 7'h2C
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sdaLow
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic gap();
		repeat (12) @(posedge clk);
	endtask
	task automatic bitx(input logic b, output logic r);
		sdaLow <= ~b;
		gap();
		scl <= 1'b1;
		gap();
		r = sda;
		scl <= 1'b0;
		gap();
	endtask
	// Byte plus acknowledge slot, MSB first
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) bitx(d[i], r[i]);
	endtask
	task automatic start();
		sdaLow <= 1'b0;
		gap();
		scl <= 1'b1;
		gap();
		sdaLow <= 1'b1;
		gap();
		scl <= 1'b0;
		gap();
	endtask
	task automatic stop();
		sdaLow <= 1'b1;
		gap();
		scl <= 1'b1;
		gap();
		sdaLow <= 1'b0;
		gap();
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [8:0] r;
		start();
		xfer({ADDR, 2'b01}, r);
		xfer({p, 1'b1}, r);
		xfer({d, 1'b1}, r);
		stop();
	endtask
	// Repeated start, one byte, then no acknowledge
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [8:0] r;
		start();
		xfer({ADDR, 2'b01}, r);
		xfer({p, 1'b1}, r);
		start();
		xfer({ADDR, 2'b11}, r);
		xfer(9'h1FF, r);
		d = r[8:1];
		stop();
	endtask
endmodule

/* File: verif/tb_top.sv */
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic bitClock = 1'b0;
	logic frameClock = 1'b0;
	logic pllOverrate = 1'b0;
	logic bitClkOn = 1'b0;
	logic scl, sdaLow, sdaOe, bridgeParallel, dspHoldInReset, clockError;
	logic [9:0] switchFreqKhz, bitclkRatioFs;
	logic [9:0] fExp = 10'h300;
	logic [1:0] mExp = 2'h0;
	logic [7:0] volumeGain, r, d;
	logic [3:0] sampleRateSel;
	logic [4:0] clockDetectStatus;
	logic [4:0] bc = 5'h00;
	logic [31:0] seed = 32'h0B86D5D5;
	logic [7:0] offs [6] = '{8'h02, 8'h03, 8'h0F, 8'h28, 8'h29, 8'h30};
	logic [7:0] rsts [6] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
	adcr_pkg::adcr_mod_t modScheme;
	adcr_pkg::adcr_pwr_t powerState;
	int num_errors = 0;
	int check_count = 0;
	wire logic sda = ~(sdaOe | sdaLow);
	adcr_regs #(.RAMP_STEP(2)) u_dut (.clk, .rst_b, .scl, .sda, .sdaDrv(), .sdaOe,
		.bitClock, .frameClock, .pllOverrate, .switchFreqKhz, .bridgeParallel, .modScheme,
		.dspHoldInReset, .volumeGain, .powerState, .bitclkRatioFs, .sampleRateSel,
		.clockDetectStatus, .clockError);
	adcr_host_model u_host (.clk, .sda, .scl, .sdaLow);
	always #2 clk = ~clk;
	// Bit clock of 80 cycles, 64 per frame; stands still while off
	always begin
		repeat (40) @(posedge clk);
		bitClock <= bitClkOn & ~bitClock;
	end
	always @(posedge bitClock) begin
		bc <= bc + 5'h01;
		if (bc == 5'h1F) frameClock <= ~frameClock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [9:0] swfOf(input logic [2:0] c, input logic [9:0] p);
		case (c)
			3'h0: return 10'h300;
			3'h1: return 10'h180;
			3'h3: return 10'h1E0;
			3'h4: return 10'h240;
			default: return p;
		endcase
	endfunction
	task automatic close_out();
		if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (95000) @(posedge clk);
		num_errors++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		`CHK("hold", 1'b1, dspHoldInReset)
		foreach (offs[i]) begin
			u_host.rd(offs[i], r);
			`CHK("rstval", rsts[i], r)
		end
		`CHK("miss", 1'b1, clockDetectStatus[adcr_pkg::ERR_MISS])
		`CHK("clkerr", 1'b1, clockError)
		u_host.wr(8'h29, 8'h7C);
		`CHK("ignored", 1'b0, clockError)
		`CHK("miss", 1'b1, clockDetectStatus[adcr_pkg::ERR_MISS])
		bitClkOn <= 1'b1;
		u_host.wr(8'h29, 8'h00);
		repeat (12000) @(posedge clk);
		`CHK("status", 5'h00, clockDetectStatus)
		`CHK("clkerr", 1'b0, clockError)
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			d = seed[7:0];
			if (i < 8) d[6:4] = i[2:0];
			if (i >= 8) d[1:0] = 2'(i - 6);
			fExp = swfOf(d[6:4], fExp);
			if (d[1:0] != 2'h3) mExp = d[1:0];
			u_host.wr(8'h02, d);
			u_host.rd(8'h02, r);
			`CHK("cfg1", d, r)
			`CHK("swf", fExp, switchFreqKhz)
			`CHK("bridge", d[2], bridgeParallel)
			`CHK("mod", mExp, modScheme)
		end
		for (int p = 0; p < 4; p++) begin
			u_host.wr(8'h03, {4'h0, p[0], 1'b0, p[1:0]});
			repeat (600) @(posedge clk);
			`CHK("hold", 1'b0, dspHoldInReset)
			`CHK("power", p[1:0], powerState)
			`CHK("gain", {8{~p[0]}}, volumeGain)
		end
		u_host.wr(8'h30, 8'hA5);
		u_host.rd(8'h30, r);
		`CHK("ro", 8'h00, r)
		u_host.rd(8'h20, r);
		`CHK("unmapped", 8'h00, r)
		for (int i = 0; i < 5; i++) begin
			u_host.wr(8'h28, 8'h39 + 8'(i * 32));
			`CHK("ratio", 10'h020 << i, bitclkRatioFs)
			`CHK("rate", 4'h9, sampleRateSel)
		end
		u_host.wr(8'h28, 8'h37);
		`CHK("ratio", 10'h020, bitclkRatioFs)
		`CHK("rate", 4'h9, sampleRateSel)
		pllOverrate <= 1'b1;
		repeat (20) @(posedge clk);
		`CHK("pll", 1'b1, clockDetectStatus[adcr_pkg::ERR_PLL])
		`CHK("clkerr", 1'b1, clockError)
		u_host.wr(8'h29, 8'h40);
		`CHK("clkerr", 1'b0, clockError)
		// Fixed 96 kHz against a slower frame: frame-rate error only
		pllOverrate <= 1'b0;
		u_host.wr(8'h28, 8'hBB);
		repeat (6000) @(posedge clk);
		`CHK("status", 5'h04, clockDetectStatus)
		`CHK("clkerr", 1'b1, clockError)
		u_host.wr(8'h29, 8'h10);
		`CHK("clkerr", 1'b0, clockError)
		`CHK("fserr", 1'b1, clockDetectStatus[adcr_pkg::ERR_FS])
		// Book 1, page 2: page end steps on to the next page
		u_host.wr(8'h7F, 8'h01);
		u_host.wr(8'h00, 8'h02);
		u_host.wr(8'h7F, 8'hA5);
		u_host.rd(8'h00, r);
		`CHK("page", 8'h03, r)
		close_out();
	end
endmodule
